// ---- ibsa_status.sv ----
// Purpose: bridge A transmit/receive status bank with APB access
// Assumes: packet side inputs are synchronous to pclk
// Notes: sticky flags clear on a status read; irq is a masked level
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ibsa_status
    import ibsa_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // transmit path
    input wire logic tx_halted,
    input wire logic tx_pkt_late,
    output logic tx_active,
    output logic tx_discard,
    // receive packet header, qualified by rx_pkt_valid
    input wire logic rx_pkt_valid,
    input wire logic rx_pkt_late,
    input wire logic [1:0] rx_emi,
    input wire logic rx_odd_even,
    input wire logic [15:0] rx_data_len,
    input wire logic rx_5060,
    input wire logic [4:0] rx_stype,
    input wire logic [5:0] rx_fmt,
    input wire logic [7:0] rx_dbc,
    input wire logic [7:0] rx_dbc_step,
    input wire logic rx_cip_bad,
    input wire logic rx_halted,
    output logic rx_active,
    output logic rx_forward,
    // link side fifo levels
    input wire logic link_fifo_full,
    input wire logic link_fifo_empty,
    // interrupt
    output logic irq
);

    // whole state of the bank
    typedef struct packed {
        ibsa_path_t tx_st;         // transmit path state
        ibsa_path_t rx_st;         // receive path state
        logic first_wait;          // waiting for first packet after start
        logic have_prev;           // a previous packet header is held
        logic [1:0] prev_emi;      // copy-control of previous packet
        logic prev_oe;             // odd/even of previous packet
        logic [7:0] prev_dbc;      // continuity counter of previous packet
        logic [7:0] prev_step;     // blocks carried by previous packet
        logic [15:0] sticky;       // sticky event flags
        logic [15:0] mask;         // interrupt mask, status layout
        logic [2:0] fmt_en;        // video, satellite, transport enables
        logic [15:0] dlen;         // expected data length
        logic fifo_full;           // sampled fifo full
        logic fifo_empty;          // sampled fifo empty
        logic [31:0] rdata;        // read data captured in setup phase
        logic tx_drop;             // discard pulse toward transmit path
        logic rx_fwd;              // forward pulse toward stream port
    } ibsa_state_t;

    ibsa_state_t cur_ff;
    ibsa_state_t nxt_ff;

    // reset image of the state
    localparam ibsa_state_t STATE_RST = '{
        tx_st: IBSA_IDLE,
        rx_st: IBSA_IDLE,
        first_wait: 1'b0,
        have_prev: 1'b0,
        prev_emi: 2'h0,
        prev_oe: 1'b0,
        prev_dbc: 8'h00,
        prev_step: 8'h00,
        sticky: 16'h0000,
        mask: 16'h0000,
        fmt_en: 3'h0,
        dlen: DLEN_RST,
        fifo_full: 1'b0,
        fifo_empty: STATUS_RST[B_EMPTY],
        rdata: 32'h0000_0000,
        tx_drop: 1'b0,
        rx_fwd: 1'b0
    };

    // true when the address hits one of the mapped words
    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == ADDR_STATUS) || (a == ADDR_CTRL) ||
                   (a == ADDR_MASK) || (a == ADDR_DLEN);
    endfunction

    // assemble the status word from live state and sticky flags
    function automatic logic [15:0] status_word(input ibsa_state_t s);
        logic [15:0] w;
        w = s.sticky & STICKY_MASK;
        w[B_TX_ACT] = (s.tx_st != IBSA_IDLE);
        w[B_RX_ACT] = (s.rx_st != IBSA_IDLE);
        w[B_FULL] = s.fifo_full;
        w[B_EMPTY] = s.fifo_empty;
        status_word = w;
    endfunction

    // apb phase decode
    logic setup_ph;
    logic access_ph;
    logic wr_ctrl;
    logic st_read;
    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr_ctrl = access_ph & pwrite & (paddr == ADDR_CTRL);
    assign st_read = access_ph & ~pwrite & (paddr == ADDR_STATUS);

    // next state logic
    always_comb begin
        logic [15:0] ev;          // events seen this cycle
        logic [15:0] clr;         // flags returned by a completing read
        logic fmt_ok;             // format code permitted by enables
        logic rx_take;            // packet accepted on the receive path
        ev = 16'h0000;
        clr = 16'h0000;
        fmt_ok = 1'b0;
        rx_take = 1'b0;
        nxt_ff = cur_ff;
        nxt_ff.tx_drop = 1'b0;
        nxt_ff.rx_fwd = 1'b0;

        // live fifo levels follow the inputs every cycle
        nxt_ff.fifo_full = link_fifo_full;
        nxt_ff.fifo_empty = link_fifo_empty;

        // transmit path: start is taken only from idle, stop only from run
        case (cur_ff.tx_st)
            IBSA_IDLE: begin
                if (wr_ctrl && pwdata[C_TX_START]) begin
                    nxt_ff.tx_st = IBSA_RUN;
                end
            end
            IBSA_RUN: begin
                if (wr_ctrl && pwdata[C_TX_STOP]) begin
                    nxt_ff.tx_st = IBSA_STOP;
                end
            end
            IBSA_STOP: begin
                // flag stays high until the path reports it has halted
                if (tx_halted) begin
                    nxt_ff.tx_st = IBSA_IDLE;
                end
            end
            default: begin
                nxt_ff.tx_st = IBSA_IDLE;
            end
        endcase

        // receive path, same shape as transmit
        case (cur_ff.rx_st)
            IBSA_IDLE: begin
                if (wr_ctrl && pwdata[C_RX_START]) begin
                    nxt_ff.rx_st = IBSA_RUN;
                    nxt_ff.first_wait = 1'b1;
                    nxt_ff.have_prev = 1'b0;
                end
            end
            IBSA_RUN: begin
                if (wr_ctrl && pwdata[C_RX_STOP]) begin
                    nxt_ff.rx_st = IBSA_STOP;
                end
            end
            IBSA_STOP: begin
                if (rx_halted) begin
                    nxt_ff.rx_st = IBSA_IDLE;
                    nxt_ff.first_wait = 1'b0;
                end
            end
            default: begin
                nxt_ff.rx_st = IBSA_IDLE;
            end
        endcase

        // a late transmit packet is dropped and flagged
        if ((cur_ff.tx_st != IBSA_IDLE) && tx_pkt_late) begin
            nxt_ff.tx_drop = 1'b1;
            ev[B_TX_LATE] = 1'b1;
        end

        // receive header checks, only while the receive path is not idle (run or stop)
        if ((cur_ff.rx_st != IBSA_IDLE) && rx_pkt_valid) begin
            if (rx_pkt_late) begin
                // late packet never reaches the stream processor port
                ev[B_RX_LATE] = 1'b1;
            end else begin
                rx_take = 1'b1;
            end
        end

        if (rx_take) begin
            nxt_ff.rx_fwd = 1'b1;
            // only the first packet after a start raises this flag
            if (cur_ff.first_wait) begin
                ev[B_FIRST] = 1'b1;
                nxt_ff.first_wait = 1'b0;
            end
            // changes are judged against the previous accepted packet
            if (cur_ff.have_prev) begin
                if (rx_emi != cur_ff.prev_emi) begin
                    ev[B_EMI_CHG] = 1'b1;
                end
                if (rx_odd_even != cur_ff.prev_oe) begin
                    ev[B_OE_CHG] = 1'b1;
                end
                if (rx_dbc != 8'(cur_ff.prev_dbc + cur_ff.prev_step)) begin
                    ev[B_DBC] = 1'b1;
                end
            end
            nxt_ff.have_prev = 1'b1;
            nxt_ff.prev_emi = rx_emi;
            nxt_ff.prev_oe = rx_odd_even;
            nxt_ff.prev_dbc = rx_dbc;
            nxt_ff.prev_step = rx_dbc_step;
            if (rx_data_len != cur_ff.dlen) begin
                ev[B_DLEN] = 1'b1;
            end
            if (rx_5060) begin
                ev[B_5060] = 1'b1;
            end
            if ((rx_stype != STYPE_A) && (rx_stype != STYPE_B)) begin
                ev[B_STYPE] = 1'b1;
            end
            if (rx_cip_bad) begin
                ev[B_CIP] = 1'b1;
            end
            fmt_ok = (cur_ff.fmt_en[2] && (rx_fmt == FMT_VIDEO)) ||
                     (cur_ff.fmt_en[1] && (rx_fmt == FMT_SAT)) ||
                     (cur_ff.fmt_en[0] && (rx_fmt == FMT_TS));
            if (!fmt_ok) begin
                ev[B_FMT] = 1'b1;
            end
        end

        // read data is captured in the setup phase, before any clear
        if (setup_ph) begin
            case (paddr)
                ADDR_STATUS: begin
                    nxt_ff.rdata = {16'h0000, status_word(cur_ff)};
                end
                ADDR_CTRL: begin
                    nxt_ff.rdata = {21'h0, cur_ff.fmt_en, 8'h00};
                end
                ADDR_MASK: begin
                    nxt_ff.rdata = {16'h0000, cur_ff.mask};
                end
                ADDR_DLEN: begin
                    nxt_ff.rdata = {16'h0000, cur_ff.dlen};
                end
                default: begin
                    nxt_ff.rdata = 32'h0000_0000;
                end
            endcase
        end

        // clear only what the read returned; a newer event is kept
        if (st_read) begin
            clr = cur_ff.rdata[15:0] & STICKY_MASK;
        end
        nxt_ff.sticky = ((cur_ff.sticky & ~clr) | ev) & STICKY_MASK;

        // register writes that store a value
        if (wr_ctrl) begin
            nxt_ff.fmt_en = pwdata[C_VID_EN:C_TRANSPORT_FORMAT_ENABLE];
        end
        if (access_ph && pwrite && (paddr == ADDR_MASK)) begin
            nxt_ff.mask = pwdata[15:0] & STICKY_MASK;
        end
        if (access_ph && pwrite && (paddr == ADDR_DLEN)) begin
            nxt_ff.dlen = pwdata[15:0];
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= STATE_RST;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // outputs; the slave always answers in the first access cycle
    assign pready = access_ph;
    assign pslverr = access_ph & ~addr_hit(paddr);
    assign prdata = cur_ff.rdata;
    assign tx_active = (cur_ff.tx_st != IBSA_IDLE);
    assign rx_active = (cur_ff.rx_st != IBSA_IDLE);
    assign tx_discard = cur_ff.tx_drop;
    assign rx_forward = cur_ff.rx_fwd;
    assign irq = |(cur_ff.sticky & cur_ff.mask);

endmodule
`default_nettype wire

// ---- ibsa_pkg.sv ----
// Purpose: constants and types for the bridge A transmit/receive status bank
// Assumes: one 100 MHz clock, APB slave with 32-bit data, 12-bit address
// Notes: status bits are sticky and clear on read, except the live ones
package ibsa_pkg;

    // register index of the status word; byte address is four times it
    localparam logic [11:0] STATUS_IDX = 12'h04e;
    localparam logic [11:0] ADDR_STATUS = {STATUS_IDX[9:0], 2'b00};
    // control, mask and length registers placed below the status word
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_MASK = 12'h004;
    localparam logic [11:0] ADDR_DLEN = 12'h008;

    // status word bit positions
    localparam int B_TX_ACT = 15;
    localparam int B_RX_ACT = 14;
    localparam int B_FIRST = 13;
    localparam int B_EMI_CHG = 12;
    localparam int B_OE_CHG = 11;
    localparam int B_DLEN = 10;
    localparam int B_TX_LATE = 8;
    localparam int B_RX_LATE = 7;
    localparam int B_5060 = 6;
    localparam int B_STYPE = 5;
    localparam int B_FULL = 4;
    localparam int B_EMPTY = 3;
    localparam int B_DBC = 2;
    localparam int B_CIP = 1;
    localparam int B_FMT = 0;

    // control word bit positions; start and stop bits are write strobes
    localparam int C_TX_START = 15;
    localparam int C_TX_STOP = 14;
    localparam int C_VID_EN = 10;
    localparam int C_SAT_EN = 9;
    localparam int C_TRANSPORT_FORMAT_ENABLE = 8;
    localparam int C_RX_START = 7;
    localparam int C_RX_STOP = 6;

    // mask of bits that a status read clears
    localparam logic [15:0] STICKY_MASK = 16'h3de7;
    // reset value of the status word (fifo empty)
    localparam logic [15:0] STATUS_RST = 16'h0008;
    // default expected data length in bytes
    localparam logic [15:0] DLEN_RST = 16'h00c0;

    // accepted cip header codes
    localparam logic [5:0] FMT_VIDEO = 6'h00;
    localparam logic [5:0] FMT_TS = 6'h20;
    localparam logic [5:0] FMT_SAT = 6'h21;
    localparam logic [4:0] STYPE_A = 5'h00;
    localparam logic [4:0] STYPE_B = 5'h01;

    // one-hot path states shared by transmit and receive
    typedef enum logic [2:0] {
        IBSA_IDLE = 3'b001,
        IBSA_RUN = 3'b010,
        IBSA_STOP = 3'b100
    } ibsa_path_t;

endpackage

// ---- ibsa_status_properties.sv ----
// Purpose: port-level properties of the bridge A status bank
// Assumes: one pclk domain, presetn asynchronous and active low
// Notes: attached by the bind below; watches design ports only
`timescale 1ns/100ps
`default_nettype none
module ibsa_status_chk
    import ibsa_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // transmit path
    input wire logic tx_pkt_late,
    input wire logic tx_active,
    input wire logic tx_discard,
    // receive path and fifo
    input wire logic rx_pkt_valid,
    input wire logic rx_pkt_late,
    input wire logic rx_5060,
    input wire logic [4:0] rx_stype,
    input wire logic rx_active,
    input wire logic rx_forward,
    input wire logic link_fifo_full
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // setup phase of a status read, where the word is captured
    sequence s_rd_stat;
        psel && !penable && !pwrite && paddr == ADDR_STATUS;
    endsequence
    // accepted non-late packet while receiving
    sequence s_pkt;
        rx_pkt_valid && !rx_pkt_late && rx_active;
    endsequence
    // completed write of the control word
    sequence s_ctl_wr;
        psel && penable && pwrite && paddr == ADDR_CTRL;
    endsequence
    AST_TX_START: assert property (
        s_ctl_wr ##0 pwdata[C_TX_START] |=> tx_active)
        else $error("tx start not taken");
    AST_RX_START: assert property (
        s_ctl_wr ##0 pwdata[C_RX_START] |=> rx_active)
        else $error("rx start not taken");
    AST_TX_DISCARD: assert property (
        tx_pkt_late && tx_active |=> tx_discard)
        else $error("late tx packet not discarded");
    AST_RX_DROP: assert property (
        rx_pkt_valid && rx_pkt_late |=> !rx_forward)
        else $error("late rx packet forwarded");
    AST_RX_FWD: assert property (
        s_pkt |=> rx_forward)
        else $error("good rx packet not forwarded");
    AST_5060: assert property (
        s_pkt ##0 rx_5060 ##1 !psel ##1 s_rd_stat |=> prdata[B_5060])
        else $error("50/60 flag missing");
    AST_STYPE: assert property (
        s_pkt ##0 rx_stype > 5'h01 ##1 !psel ##1 s_rd_stat |=> prdata[B_STYPE])
        else $error("subtype flag missing");
    AST_FULL_LIVE: assert property (
        s_rd_stat |=> prdata[B_FULL] == $past(link_fifo_full, 2))
        else $error("fifo full bit not live");
endmodule
bind ibsa_status ibsa_status_chk u_ibsa_status_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .tx_pkt_late, .tx_active, .tx_discard, .rx_pkt_valid, .rx_pkt_late,
    .rx_5060, .rx_stype, .rx_active, .rx_forward, .link_fifo_full
);
`default_nettype wire

// ---- ibsa_tsp_model.sv ----
// Purpose: stream processor port seen from the bridge A bank
// Assumes: forward and discard pulses last one pclk cycle
// Notes: only counts; it never stalls because the bank has no buffer
`timescale 1ns/100ps
`default_nettype none
module ibsa_tsp_model (
    // clock
    input wire logic pclk,
    // pulses from the bank
    input wire logic rx_forward,
    input wire logic tx_discard
);
    // packets handed over and packets thrown away
    logic [31:0] fwd_n = 32'h0;
    logic [31:0] disc_n = 32'h0;
    // count each pulse once; unknown pulses are not counted
    always @(posedge pclk) begin
        if (rx_forward === 1'b1) begin
            fwd_n <= fwd_n + 32'h1;
        end
        if (tx_discard === 1'b1) begin
            disc_n <= disc_n + 32'h1;
        end
    end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: directed apb bench for the bridge A status bank
// Assumes: zero wait state apb, header fields held in one bench word
// Notes: expected words are built from the status bit layout
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ibsa_pkg::*;
    // apb master side
    logic pclk = 1'b0, presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e;
    // link side levels and pulses
    logic tx_halted = 1'b0, rx_halted = 1'b0, tx_pkt_late = 1'b0;
    logic link_fifo_full = 1'b0, link_fifo_empty = 1'b1;
    logic rx_pkt_valid = 1'b0, rx_pkt_late = 1'b0;
    // header fields, all carried by hdr
    logic [47:0] hdr = 48'h0;
    logic [1:0] rx_emi;
    logic [15:0] rx_data_len;
    logic [4:0] rx_stype;
    logic [5:0] rx_fmt;
    logic [7:0] rx_dbc, rx_dbc_step;
    logic rx_odd_even, rx_5060, rx_cip_bad;
    // design outputs
    logic tx_active, tx_discard, rx_active, rx_forward, irq;
    // counters and format table (error expected where fe is set)
    int n_errors = 0;
    int tests_run = 0;
    logic [5:0] fm [4] = '{6'h00, 6'h20, 6'h21, 6'h3f};
    logic [3:0] fe = 4'b1101;
    assign {rx_emi, rx_odd_even, rx_data_len, rx_5060, rx_stype, rx_fmt,
        rx_dbc, rx_dbc_step, rx_cip_bad} = hdr;
    // 100 MHz clock
    always #5 pclk = ~pclk;
    ibsa_status u_ibsa_status (.*);
    ibsa_tsp_model u_ibsa_tsp_model (.*);
    // header word, dbc step fixed at eight blocks
    function automatic logic [47:0] hd(input logic [1:0] em,
        input logic oe, input logic [15:0] ln, input logic f,
        input logic [4:0] st, input logic [5:0] fmt, input logic [7:0] d,
        input logic bad);
        return {em, oe, ln, f, st, fmt, d, 8'h08, bad};
    endfunction
    // one value comparison
    task automatic chk(input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            n_errors++;
            $display("MISMATCH %0t exp %h got %h", $time, x, g);
        end
    endtask
    // one apb transfer; held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // only the watchdog ends a wait for the slave's answer
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(x, q);
    endtask
    // one header pulse; fields lose the last value afterwards
    task automatic pk(input logic l, input logic [47:0] h);
        @(posedge pclk);
        rx_pkt_valid <= 1'b1;
        rx_pkt_late <= l;
        hdr <= h;
        @(posedge pclk);
        rx_pkt_valid <= 1'b0;
        hdr <= ~h;
    endtask
    task automatic txl();
        @(posedge pclk);
        tx_pkt_late <= 1'b1;
        @(posedge pclk);
        tx_pkt_late <= 1'b0;
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // the whole run takes well under a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_STATUS, 32'h0008);
        apb(1'b0, 12'h010, 32'h0);
        chk(32'h1, {31'h0, e});
        done("reset");
        // start both paths, transport format only
        apb(1'b1, ADDR_CTRL, 32'h8180);
        rd(ADDR_STATUS, 32'hc008);
        pk(1'b0, hd(2'h0, 1'b0, 16'h00c0, 1'b0, 5'h00, 6'h20, 8'h00, 1'b0));
        rd(ADDR_STATUS, 32'he008);
        pk(1'b0, hd(2'h0, 1'b0, 16'h00c0, 1'b0, 5'h01, 6'h20, 8'h08, 1'b0));
        rd(ADDR_STATUS, 32'hc008);
        // every header check fails at once
        pk(1'b0, hd(2'h1, 1'b1, 16'h0010, 1'b1, 5'h02, 6'h00, 8'h20, 1'b1));
        rd(ADDR_STATUS, 32'hdc6f);
        rd(ADDR_STATUS, 32'hc008);
        for (int i = 0; i < 4; i++) begin
            pk(1'b0, hd(2'h1, 1'b1, 16'h00c0, 1'b0, 5'(i % 2), fm[i],
                8'(40 + 8 * i), 1'b0));
            rd(ADDR_STATUS, {16'h0, 16'hc008 | 16'(fe[i])});
        end
        done("header");
        // late packets on both paths
        pk(1'b1, hd(2'h1, 1'b1, 16'h00c0, 1'b0, 5'h00, 6'h20, 8'h48, 1'b0));
        txl();
        rd(ADDR_STATUS, 32'hc188);
        chk(32'h7, u_ibsa_tsp_model.fwd_n);
        chk(32'h1, u_ibsa_tsp_model.disc_n);
        link_fifo_full <= 1'b1;
        link_fifo_empty <= 1'b0;
        rd(ADDR_STATUS, 32'hc010);
        rd(ADDR_STATUS, 32'hc010);
        done("late and fifo");
        // only the rx late event may raise the interrupt
        apb(1'b1, ADDR_MASK, 32'h0080);
        txl();
        #1;
        chk(32'h0, {31'h0, irq});
        pk(1'b1, hd(2'h1, 1'b1, 16'h00c0, 1'b0, 5'h00, 6'h20, 8'h50, 1'b0));
        #1;
        chk(32'h1, {31'h0, irq});
        rd(ADDR_STATUS, 32'hc190);
        #1;
        chk(32'h0, {31'h0, irq});
        done("interrupt");
        // every format enabled, shorter expected length
        apb(1'b1, ADDR_CTRL, 32'h0700);
        rd(ADDR_CTRL, 32'h0700);
        apb(1'b1, ADDR_DLEN, 32'h0010);
        rd(ADDR_DLEN, 32'h0010);
        rd(ADDR_MASK, 32'h0080);
        pk(1'b0, hd(2'h1, 1'b1, 16'h0010, 1'b0, 5'h00, 6'h00, 8'h48, 1'b0));
        rd(ADDR_STATUS, 32'hc010);
        pk(1'b0, hd(2'h1, 1'b1, 16'h0010, 1'b0, 5'h01, 6'h21, 8'h50, 1'b0));
        rd(ADDR_STATUS, 32'hc010);
        pk(1'b0, hd(2'h1, 1'b1, 16'h00c0, 1'b0, 5'h00, 6'h20, 8'h58, 1'b0));
        rd(ADDR_STATUS, 32'hc410);
        done("formats");
        // stop holds the paths active until they report halted
        apb(1'b1, ADDR_CTRL, 32'h4140);
        rd(ADDR_STATUS, 32'hc010);
        chk(32'h3, {30'h0, tx_active, rx_active});
        tx_halted <= 1'b1;
        rx_halted <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(ADDR_STATUS, 32'h0010);
        chk(32'h0, {30'h0, tx_active, rx_active});
        done("stop");
        tally_and_finish();
    end
endmodule
`default_nettype wire
